// *** hdl/asc_pkg.sv ***
package asc_pkg;

    // ==========================================================
    // configuration word layout
    localparam int CFG_WIDTH = 12;
    localparam int MASK_WIDTH = 8;
    localparam int PM_HI_BIT = 11;
    localparam int PM_LO_BIT = 10;
    localparam int ADDR_HI_BIT = 7;
    localparam int ADDR_LO_BIT = 5;
    localparam int ICFG_HI_BIT = 4;
    localparam int ICFG_LO_BIT = 3;
    localparam int MASK_SEL_BIT = 2;
    localparam int SEQ_EN_BIT = 1;

    // ==========================================================
    // modes and states
    typedef enum logic [1:0] {
        PM_NORMAL = 2'b00,
        PM_AUTO_SD = 2'b01,
        PM_AUTO_STBY = 2'b10,
        PM_FULL_SD = 2'b11
    } asc_pm_type;

    // value is {input_config_hi, input_config_lo}
    typedef enum logic [1:0] {
        IC_SINGLE = 2'b00,
        IC_PSEUDO1 = 2'b01,
        IC_DIFF = 2'b10,
        IC_PSEUDO2 = 2'b11
    } asc_icfg_type;

    typedef enum logic [1:0] {
        ST_SINGLE = 2'b00,
        ST_MASK_WAIT = 2'b01,
        ST_MASK_RUN = 2'b10,
        ST_RANGE_RUN = 2'b11
    } asc_seq_type;

    typedef enum logic [1:0] {
        PW_IDLE = 2'b00,
        PW_WAKE = 2'b01,
        PW_CONV = 2'b10
    } asc_pw_type;

    // {sequence_enable, mask_select} codes of a configuration write
    localparam logic [1:0] SEQCTL_SINGLE = 2'b00;
    localparam logic [1:0] SEQCTL_MASK_PROG = 2'b01;
    localparam logic [1:0] SEQCTL_KEEP = 2'b10;
    localparam logic [1:0] SEQCTL_RANGE = 2'b11;

    // ==========================================================
    // reset values and channel constants
    localparam logic [2:0] ADDR_RST = 3'h0;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [2:0] LAST_CHAN = 3'h7;
    localparam logic [2:0] CHAN_COMMON_NEG = 3'h7;
    localparam logic [2:0] PAIR_SWAP = 3'h1;
    localparam logic [7:0] PAIR_EVEN_MASK = 8'h55;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int STANDBY_WAKE_NS = 1000;
    localparam int SHUTDOWN_WAKE_NS = 1000;
    localparam int WAKE_CNT_WIDTH = 8;
    // longest times: round down, never below one cycle
    localparam int STANDBY_WAKE_CYC =
        (STANDBY_WAKE_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (STANDBY_WAKE_NS / CLK_PERIOD_NS);
    localparam int SHUTDOWN_WAKE_CYC =
        (SHUTDOWN_WAKE_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (SHUTDOWN_WAKE_NS / CLK_PERIOD_NS);

endpackage

// *** hdl/asc_chan_if.sv ***
`timescale 1ns/10ps
interface asc_chan_if;
    import asc_pkg::*;
    logic [2:0] addr;
    asc_icfg_type icfg;
    logic [2:0] pos;
    logic [2:0] neg;
    logic neg_gnd;

    modport decoder (input addr, input icfg,
                     output pos, output neg, output neg_gnd);
    modport user (output addr, output icfg,
                  input pos, input neg, input neg_gnd);
endinterface

// *** hdl/asc_chan_decode.sv ***
`timescale 1ns/10ps
module asc_chan_decode
    import asc_pkg::*;
(
    // channel address and input configuration in, pins out
    asc_chan_if.decoder chan
);

    // ==========================================================
    // address to positive / negative input
    always_comb begin
        chan.pos = chan.addr;
        chan.neg = chan.addr;
        chan.neg_gnd = 1'b0;
        case (chan.icfg)
            IC_SINGLE: begin
                chan.neg_gnd = 1'b1;
            end
            IC_DIFF, IC_PSEUDO1: begin
                // odd address swaps the pair polarity
                chan.neg = chan.addr ^ PAIR_SWAP;
            end
            IC_PSEUDO2: begin
                // address 7 is not a legal pick here
                chan.neg = CHAN_COMMON_NEG;
            end
            default: begin
                chan.neg_gnd = 1'b1;
            end
        endcase
    end

endmodule

// *** hdl/asc_seq_power_ctrl.sv ***
`timescale 1ns/10ps
// Contract
// - power mode field selects four modes
// - auto shutdown powers off after conversion
// - auto standby partial, wakes within 1 us
// - full shutdown keeps configuration intact
// - single-ended: address positive, ground negative
// - differential pairs, odd address swaps polarity
// - pseudo mode one pairs like differential
// - pseudo mode two: input 7 negative
// - idle sequencer uses last written address
// - mask-select routes next write to mask
// - keep code leaves running sequence alone
// - range sequence from channel 0 to address
// - mask is eight write-only low bits
// - mask loads only after mask-select write
// - mask bit n enables input n
// - each start advances to next enabled
// - sequence ends on non-keep configuration write
// - paired sequence converts normal polarity only
// - twelve-bit configuration field layout
// - configuration clears to zero at reset
module asc_seq_power_ctrl
    import asc_pkg::*;
#(
    parameter int STBY_WAKE_CYCLES = STANDBY_WAKE_CYC,
    parameter int SD_WAKE_CYCLES = SHUTDOWN_WAKE_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // host parallel write port
    input wire logic i_cs_n,
    input wire logic i_wr_n,
    input wire logic [CFG_WIDTH-1:0] i_data_bus,
    // conversion control
    input wire logic i_convert_start_n,
    input wire logic i_conv_done,
    // conversion request to the converter core
    output logic o_conv_go,
    output logic [2:0] o_conv_pos,
    output logic [2:0] o_conv_neg,
    output logic o_conv_neg_gnd,
    // power control
    output logic o_pw_full,
    output logic o_pw_partial,
    output logic o_pw_off,
    // status
    output logic o_seq_active
);

    localparam logic [WAKE_CNT_WIDTH-1:0] STBY_LOAD =
        WAKE_CNT_WIDTH'(STBY_WAKE_CYCLES - 1);
    localparam logic [WAKE_CNT_WIDTH-1:0] SD_LOAD =
        WAKE_CNT_WIDTH'(SD_WAKE_CYCLES - 1);
    localparam int CHK_WAKE_MAX = STBY_WAKE_CYCLES + 1;

    // ==========================================================
    // helper functions
    // channels the sequencer may visit; pairs only on even side
    function automatic logic [7:0] eligible_set(
        input logic range_mode,
        input logic [7:0] mask,
        input logic [2:0] last,
        input asc_icfg_type icfg
    );
        logic [7:0] set;
        set = 8'h00;
        for (int i = 0; i < MASK_WIDTH; i++) begin
            set[i] = range_mode ? (3'(i) <= last) : mask[i];
        end
        if (icfg == IC_DIFF || icfg == IC_PSEUDO1) begin
            // inverse pair never converted, host sets both bits
            set = set & PAIR_EVEN_MASK;
        end
        return set;
    endfunction

    // lowest enabled channel above cur, else lowest enabled
    function automatic logic [2:0] next_channel(
        input logic [7:0] set,
        input logic [2:0] cur
    );
        logic [2:0] res;
        logic found;
        res = 3'h0;
        found = 1'b0;
        for (int i = MASK_WIDTH - 1; i >= 0; i--) begin
            if (set[i] && 3'(i) > cur) begin
                res = 3'(i);
                found = 1'b1;
            end
        end
        if (!found) begin
            for (int i = MASK_WIDTH - 1; i >= 0; i--) begin
                if (set[i]) begin
                    res = 3'(i);
                end
            end
        end
        return res;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic cs_meta_r, cs_s_r, cs_d_r;
    logic wr_meta_r, wr_s_r, wr_d_r;
    logic cv_meta_r, cv_s_r, cv_d_r;
    logic [CFG_WIDTH-1:0] data_meta_r, data_s_r;

    // data goes through the same two stages as the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cs_meta_r <= 1'b1;
            cs_s_r <= 1'b1;
            cs_d_r <= 1'b1;
            wr_meta_r <= 1'b1;
            wr_s_r <= 1'b1;
            wr_d_r <= 1'b1;
            cv_meta_r <= 1'b1;
            cv_s_r <= 1'b1;
            cv_d_r <= 1'b1;
            data_meta_r <= 12'h000;
            data_s_r <= 12'h000;
        end else begin
            cs_meta_r <= i_cs_n;
            cs_s_r <= cs_meta_r;
            cs_d_r <= cs_s_r;
            wr_meta_r <= i_wr_n;
            wr_s_r <= wr_meta_r;
            wr_d_r <= wr_s_r;
            cv_meta_r <= i_convert_start_n;
            cv_s_r <= cv_meta_r;
            cv_d_r <= cv_s_r;
            data_meta_r <= i_data_bus;
            data_s_r <= data_meta_r;
        end
    end

    // ==========================================================
    // write decode and registers
    logic wr_evt, cfg_wr, mask_wr, cv_fall, accept, seq_running;
    logic [1:0] seqctl;
    asc_pm_type pm_r;
    asc_icfg_type icfg_r;
    asc_seq_type seq_state_r;
    asc_pw_type pw_state_r;
    logic [2:0] addr_r, cur_ch_r, sel_ch;
    logic [7:0] channel_sequence_mask_r, live_set;
    logic [WAKE_CNT_WIDTH-1:0] wake_cnt_r;

    // write taken on rising strobe while chip select was low
    assign wr_evt = wr_s_r & ~wr_d_r & ~cs_d_r;
    // a write right after mask-select always lands in the mask
    assign mask_wr = wr_evt & (seq_state_r == ST_MASK_WAIT);
    assign cfg_wr = wr_evt & (seq_state_r != ST_MASK_WAIT);
    assign seqctl = {data_s_r[SEQ_EN_BIT], data_s_r[MASK_SEL_BIT]};
    assign cv_fall = cv_d_r & ~cv_s_r;
    assign seq_running = (seq_state_r == ST_MASK_RUN) ||
                         (seq_state_r == ST_RANGE_RUN);

    // configuration fields; power modes never clear them
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pm_r <= PM_NORMAL;
            addr_r <= ADDR_RST;
            icfg_r <= IC_SINGLE;
        end else if (cfg_wr) begin
            pm_r <= asc_pm_type'(data_s_r[PM_HI_BIT:PM_LO_BIT]);
            addr_r <= data_s_r[ADDR_HI_BIT:ADDR_LO_BIT];
            icfg_r <= asc_icfg_type'(data_s_r[ICFG_HI_BIT:ICFG_LO_BIT]);
        end
    end

    // write-only channel mask, low byte of the bus
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            channel_sequence_mask_r <= MASK_RST;
        end else if (mask_wr) begin
            channel_sequence_mask_r <= data_s_r[MASK_WIDTH-1:0];
        end
    end

    // ==========================================================
    // sequencer
    assign live_set = eligible_set(seq_state_r == ST_RANGE_RUN,
                                   channel_sequence_mask_r, addr_r,
                                   icfg_r);
    // idle sequencer takes the address of the last write
    assign sel_ch = seq_running ? cur_ch_r : addr_r;

    // a mask or range write in the same cycle as a start wins the channel
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            seq_state_r <= ST_SINGLE;
            cur_ch_r <= ADDR_RST;
        end else begin
            if (accept && seq_running) begin
                cur_ch_r <= next_channel(live_set, cur_ch_r);
            end
            if (mask_wr) begin
                seq_state_r <= ST_MASK_RUN;
                cur_ch_r <= next_channel(
                    eligible_set(1'b0, data_s_r[MASK_WIDTH-1:0],
                                 addr_r, icfg_r), LAST_CHAN);
            end else if (cfg_wr) begin
                case (seqctl)
                    SEQCTL_SINGLE: begin
                        seq_state_r <= ST_SINGLE;
                    end
                    SEQCTL_MASK_PROG: begin
                        seq_state_r <= ST_MASK_WAIT;
                    end
                    SEQCTL_KEEP: begin
                        seq_state_r <= seq_state_r;
                    end
                    SEQCTL_RANGE: begin
                        seq_state_r <= ST_RANGE_RUN;
                        cur_ch_r <= next_channel(
                            eligible_set(1'b1, MASK_RST,
                                data_s_r[ADDR_HI_BIT:ADDR_LO_BIT],
                                asc_icfg_type'(
                                data_s_r[ICFG_HI_BIT:ICFG_LO_BIT])),
                            LAST_CHAN);
                    end
                    default: begin
                        seq_state_r <= ST_SINGLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // channel decode and sample capture
    asc_chan_if chan ();

    assign chan.addr = sel_ch;
    assign chan.icfg = icfg_r;

    asc_chan_decode u_decode (
        .chan (chan.decoder)
    );

    // inputs are latched at the start edge, the sample instant
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_conv_pos <= ADDR_RST;
            o_conv_neg <= ADDR_RST;
            o_conv_neg_gnd <= 1'b1;
        end else if (accept) begin
            o_conv_pos <= chan.pos;
            o_conv_neg <= chan.neg;
            o_conv_neg_gnd <= chan.neg_gnd;
        end
    end

    // ==========================================================
    // power sequencing
    // starts during wake or conversion are dropped, not queued
    assign accept = cv_fall && (pw_state_r == PW_IDLE) &&
                    (pm_r != PM_FULL_SD);

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pw_state_r <= PW_IDLE;
            wake_cnt_r <= '0;
            o_conv_go <= 1'b0;
        end else begin
            o_conv_go <= 1'b0;
            case (pw_state_r)
                PW_IDLE: begin
                    if (accept && pm_r == PM_NORMAL) begin
                        o_conv_go <= 1'b1;
                        pw_state_r <= PW_CONV;
                    end else if (accept) begin
                        wake_cnt_r <= (pm_r == PM_AUTO_STBY) ?
                                      STBY_LOAD : SD_LOAD;
                        pw_state_r <= PW_WAKE;
                    end
                end
                PW_WAKE: begin
                    if (wake_cnt_r == '0) begin
                        o_conv_go <= 1'b1;
                        pw_state_r <= PW_CONV;
                    end else begin
                        wake_cnt_r <= wake_cnt_r - 1'b1;
                    end
                end
                PW_CONV: begin
                    if (i_conv_done) begin
                        pw_state_r <= PW_IDLE;
                    end
                end
                default: begin
                    pw_state_r <= PW_IDLE;
                end
            endcase
        end
    end

    // power rails follow the mode while idle
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_pw_full <= 1'b1;
            o_pw_partial <= 1'b0;
            o_pw_off <= 1'b0;
            o_seq_active <= 1'b0;
        end else begin
            o_seq_active <= seq_running;
            o_pw_full <= (pw_state_r != PW_IDLE) ||
                         (pm_r == PM_NORMAL);
            o_pw_partial <= (pw_state_r == PW_IDLE) &&
                            (pm_r == PM_AUTO_STBY);
            o_pw_off <= (pw_state_r == PW_IDLE) &&
                        (pm_r == PM_AUTO_SD || pm_r == PM_FULL_SD);
        end
    end

    // ==========================================================
    // checks
    chk_normal_on: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        pm_r == PM_NORMAL |=> o_pw_full && !o_pw_off && !o_pw_partial)
        else $error("normal mode not fully powered");

    chk_auto_sd_off: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        pw_state_r == PW_CONV && i_conv_done && pm_r == PM_AUTO_SD
        ##1 pm_r == PM_AUTO_SD |=> o_pw_off && !o_pw_full)
        else $error("auto shutdown did not power off");

    chk_stby_wake: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        accept && pm_r == PM_AUTO_STBY |-> ##[1:CHK_WAKE_MAX] o_conv_go)
        else $error("standby wake too slow");

    chk_full_sd_hold: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        pm_r == PM_FULL_SD && !cfg_wr |=> $stable(addr_r) &&
        $stable(icfg_r) && !o_conv_go && pw_state_r == PW_IDLE)
        else $error("full shutdown lost state or converted");

    chk_single_addr: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        accept && seq_state_r == ST_SINGLE && icfg_r == IC_SINGLE
        |=> o_conv_pos == $past(addr_r) && o_conv_neg_gnd)
        else $error("single conversion used wrong address");

    chk_pair_swap: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        accept && (icfg_r == IC_DIFF || icfg_r == IC_PSEUDO1)
        |=> o_conv_neg == (o_conv_pos ^ PAIR_SWAP) && !o_conv_neg_gnd)
        else $error("pair polarity wrong");

    chk_common_neg: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        accept && icfg_r == IC_PSEUDO2
        |=> o_conv_neg == CHAN_COMMON_NEG && !o_conv_neg_gnd)
        else $error("common negative not input 7");

    chk_mask_load: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        wr_evt && seq_state_r == ST_MASK_WAIT
        |=> channel_sequence_mask_r == MASK_WIDTH'($past(data_s_r)) &&
        seq_state_r == ST_MASK_RUN)
        else $error("mask write not taken");

    chk_seq_keep: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        cfg_wr && seqctl == SEQCTL_KEEP && seq_running
        |=> $stable(seq_state_r))
        else $error("keep write ended the sequence");

    chk_seq_stop: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        cfg_wr && seqctl == SEQCTL_SINGLE ##1 !wr_evt [*2]
        |=> !o_seq_active)
        else $error("sequence not stopped");

    chk_normal_only: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        accept && seq_running &&
        (icfg_r == IC_DIFF || icfg_r == IC_PSEUDO1)
        |=> o_conv_pos[0] == 1'b0)
        else $error("inverse pair converted in sequence");

    chk_range_start: assert property (
        @(posedge i_ref_clk) disable iff (i_reset)
        cfg_wr && seqctl == SEQCTL_RANGE |=> cur_ch_r == 3'h0)
        else $error("range sequence not starting at 0");

endmodule

// *** sim/asc_core_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// converter core stand-in: answers each start after a set delay
module asc_core_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // start request and answer delay in cycles, one or more
    input wire logic i_conv_go,
    input wire logic [3:0] i_latency,
    // finish pulse back to the sequencer
    output logic o_conv_done
);
    logic [3:0] cnt_r;

    // count down; done pulses for one cycle as the count steps from one to zero
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cnt_r <= 4'h0;
            o_conv_done <= 1'b0;
        end else if (i_conv_go) begin
            cnt_r <= i_latency;
            o_conv_done <= 1'b0;
        end else begin
            o_conv_done <= (cnt_r == 4'h1);
            if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

// *** sim/asc_seq_power_ctrl_bench.sv ***
`timescale 1ns/10ps
module asc_seq_power_ctrl_bench;
    import asc_pkg::*;
    // short wake time keeps the run brief
    localparam int WAKE = 2;
    // ==========================================================
    // pins and bookkeeping
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_cs_n = 1'b1;
    logic i_wr_n = 1'b1;
    logic [CFG_WIDTH-1:0] i_data_bus = 12'h000;
    logic i_convert_start_n = 1'b1;
    logic i_conv_done;
    logic [3:0] latency = 4'h2;
    logic o_conv_go, o_conv_neg_gnd, o_pw_full, o_pw_partial, o_pw_off;
    logic o_seq_active;
    logic [2:0] o_conv_pos, o_conv_neg;
    logic [6:0] exp_q[$];
    logic [6:0] got;
    int fails = 0;
    int n_compared = 0;
    int go_cnt = 0;
    int cur_ch;

    always #50 i_ref_clk = ~i_ref_clk;

    asc_seq_power_ctrl #(.STBY_WAKE_CYCLES(WAKE), .SD_WAKE_CYCLES(WAKE))
    DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cs_n(i_cs_n),
        .i_wr_n(i_wr_n), .i_data_bus(i_data_bus),
        .i_convert_start_n(i_convert_start_n), .i_conv_done(i_conv_done),
        .o_conv_go(o_conv_go), .o_conv_pos(o_conv_pos),
        .o_conv_neg(o_conv_neg), .o_conv_neg_gnd(o_conv_neg_gnd),
        .o_pw_full(o_pw_full), .o_pw_partial(o_pw_partial),
        .o_pw_off(o_pw_off), .o_seq_active(o_seq_active));

    asc_core_model core (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_conv_go(o_conv_go), .i_latency(latency),
        .o_conv_done(i_conv_done));

    // ==========================================================
    // helpers
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t ns: %s", $time, msg);
        end
    endtask

    task automatic conclude();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ignored bits 9, 8 and 0 carry noise on purpose
    function automatic logic [11:0] cfg(input logic [1:0] pm,
        input logic [2:0] a, input logic [1:0] ic, input logic [1:0] sc);
        logic [2:0] junk;
        junk = 3'($urandom);
        return {pm, junk[2:1], a, ic, sc[0], sc[1], junk[0]};
    endfunction

    // expected {pos, neg, gnd} of one address
    function automatic logic [6:0] dec(input int a, input logic [1:0] ic);
        logic [2:0] p;
        p = 3'(a);
        if (ic == IC_SINGLE) return {p, 3'h0, 1'b1};
        if (ic == IC_PSEUDO2) return {p, 3'h7, 1'b0};
        return {p, p ^ 3'h1, 1'b0};
    endfunction

    // next enabled channel above cur, wrapping to the lowest
    function automatic int nxt(input logic [7:0] s, input int cur);
        for (int k = 1; k <= 8; k++) begin
            if (s[(cur + k) % 8] === 1'b1) return (cur + k) % 8;
        end
        return cur;
    endfunction

    // host write: strobe low and high phases of three cycles each
    task automatic write_word(input logic [11:0] d);
        @(negedge i_ref_clk);
        i_data_bus = d;
        i_cs_n = 1'b0;
        i_wr_n = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        i_wr_n = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        i_cs_n = 1'b1;
        i_data_bus = ~d; // released bus must not keep its value
        repeat (2) @(negedge i_ref_clk);
    endtask

    // start pulse, then a bounded wait for the core request
    task automatic convert(input logic [6:0] e, input bit want);
        int w;
        int c0;
        latency = 4'($urandom_range(6, 1));
        if (want) exp_q.push_back(e);
        c0 = go_cnt;
        @(negedge i_ref_clk);
        i_convert_start_n = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        i_convert_start_n = 1'b1;
        w = 0;
        while (go_cnt == c0 && w < 30) begin
            @(negedge i_ref_clk);
            w++;
        end
        check((go_cnt != c0) == want, "start answer");
        repeat (10) @(negedge i_ref_clk);
    endtask

    task automatic run_chain(input logic [7:0] s, input logic [1:0] ic,
        input int n);
        repeat (n) begin
            convert(dec(cur_ch, ic), 1'b1);
            cur_ch = nxt(s, cur_ch);
        end
    endtask

    // ==========================================================
    // result watcher: each request is matched to the oldest note
    always @(negedge i_ref_clk) begin
        if (o_conv_go === 1'b1) begin
            go_cnt++;
            // a request with no note is a stray start, never a match
            check(exp_q.size() > 0, "unexpected request");
            got = (exp_q.size() > 0) ? exp_q.pop_front() : 7'h7F;
            check(o_conv_pos === got[6:4] && o_conv_neg_gnd === got[0] &&
                (got[0] || o_conv_neg === got[3:1]), "channel");
        end
    end

    // watchdog: the tests take well under a millisecond
    initial begin
        #1000000;
        fails++;
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] m;
        int a;
        a = $urandom(32'hd357);
        repeat (20) @(negedge i_ref_clk);
        i_reset = 1'b0;
        @(negedge i_ref_clk);
        check(o_pw_full === 1'b1 && o_pw_partial === 1'b0 &&
            o_pw_off === 1'b0 && o_seq_active === 1'b0, "reset");
        convert(dec(0, IC_SINGLE), 1'b1);
        // every input configuration, random addresses
        for (int ic = 0; ic < 4; ic++) begin
            repeat (4) begin
                a = (ic == 3) ? $urandom_range(6, 0) : $urandom_range(7, 0);
                write_word(cfg(PM_NORMAL, 3'(a), 2'(ic), SEQCTL_SINGLE));
                convert(dec(a, 2'(ic)), 1'b1);
            end
        end
        // every power mode; full shutdown drops the start
        for (int pm = 0; pm < 4; pm++) begin
            write_word(cfg(2'(pm), 3'h2, IC_SINGLE, SEQCTL_SINGLE));
            convert(dec(2, IC_SINGLE), pm != 3);
            check(o_pw_full === (pm == 0) && o_pw_off === pm[0] &&
                o_pw_partial === (pm == 2), "power level");
        end
        // mask chain, single-ended, then keep and stop writes
        m = 8'($urandom_range(255, 1));
        write_word(cfg(PM_NORMAL, 3'h0, IC_SINGLE, SEQCTL_MASK_PROG));
        write_word({4'($urandom), m});
        check(o_seq_active === 1'b1, "mask chain on");
        cur_ch = nxt(m, 7);
        run_chain(m, IC_SINGLE, 10);
        write_word(cfg(PM_AUTO_SD, 3'h5, IC_SINGLE, SEQCTL_KEEP));
        check(o_seq_active === 1'b1, "keep write");
        run_chain(m, IC_SINGLE, 4);
        write_word(cfg(PM_NORMAL, 3'h3, IC_SINGLE, SEQCTL_SINGLE));
        check(o_seq_active === 1'b0, "chain stop");
        convert(dec(3, IC_SINGLE), 1'b1);
        // paired mask chain: normal polarity only
        m = 8'($urandom) & 8'h55 | 8'h01;
        write_word(cfg(PM_NORMAL, 3'h0, IC_DIFF, SEQCTL_MASK_PROG));
        write_word({4'h0, m | (m << 1)});
        cur_ch = nxt(m, 7);
        run_chain(m, IC_DIFF, 6);
        // range chains from channel 0 to the address
        write_word(cfg(PM_NORMAL, 3'h5, IC_SINGLE, SEQCTL_RANGE));
        check(o_seq_active === 1'b1, "range on");
        cur_ch = 0;
        run_chain(8'h3F, IC_SINGLE, 8);
        write_word(cfg(PM_NORMAL, 3'h6, IC_PSEUDO2, SEQCTL_RANGE));
        cur_ch = 0;
        run_chain(8'h7F, IC_PSEUDO2, 9);
        check(exp_q.size() == 0, "requests left over");
        conclude();
    end
endmodule
